// *** hdl/buck_fault_hiccup_sequencer.sv ***
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module buck_fault_hiccup_sequencer
  import buck_seq_pkg::*;
#(
  parameter int unsigned SS_CYCLES = SS_PERIOD_CYCLES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // pins, asynchronous to sys_clk
  input wire logic shutdown_req_pin,
  input wire logic shutdown_req_pin_oe,
  input wire logic sync_pin,
  // comparators, asynchronous to sys_clk
  input wire sense_t sense,
  // power stage
  output logic upper_switch_on,
  output logic ramp_reset,
  output logic ss_discharge,
  // power-good open drain, pin driven low while oe high
  output logic output_in_window_o,
  output logic output_in_window_oe,
  // register port
  input wire reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  // interrupt
  output logic irq
);
  localparam int unsigned SYNC_W = 10;

  logic [SYNC_W-1:0] raw_in, rst_val, syn;
  logic shdn, sync_lv, oc_ev, fb_hi, fb_lo, fb_uv, t_hot, t_cool, rail_ok, ss_done;

  // an undriven request pin floats high through the internal pull-up
  assign raw_in = {shutdown_req_pin | ~shutdown_req_pin_oe, sync_pin, sense};
  assign rst_val = {1'b1, {(SYNC_W-1){1'b0}}};

  pin_sync3 #(.W(SYNC_W)) u_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .pin_in(raw_in ^ rst_val),
    .reset_val(rst_val),
    .pin_out(syn)
  );
  assign {shdn, sync_lv, oc_ev, fb_hi, fb_lo, fb_uv, t_hot, t_cool, rail_ok, ss_done} = syn;

  function automatic logic [CNT_W-1:0] inc(input logic [CNT_W-1:0] v);
    return v + 1'b1;
  endfunction

  // oscillator: ramp ends on rising sync or on free-running timeout
  logic sync_prev_q, sync_prev_d;
  logic [TIMER_W-1:0] osc_q, osc_d;
  logic [TIMER_W-1:0] off_q, off_d;
  logic cycle_start, sync_rise;

  assign sync_rise = sync_lv & ~sync_prev_q;
  assign cycle_start = (off_q == TIMER_W'(1));

  always_comb begin
    sync_prev_d = sync_lv;
    osc_d = osc_q + 1'b1;
    off_d = (off_q != '0) ? off_q - 1'b1 : off_q;
    if (off_q == '0 && (sync_rise || osc_q >= TIMER_W'(OSC_PERIOD_CYCLES - 1))) begin
      osc_d = '0;
      off_d = TIMER_W'(OFF_CYCLES);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_prev_q <= 1'b0;
      osc_q <= '0;
      off_q <= '0;
    end else if (clk_en) begin
      sync_prev_q <= sync_prev_d;
      osc_q <= osc_d;
      off_q <= off_d;
    end
  end

  assign ramp_reset = (off_q != '0);

  // sequencer with overcurrent accounting
  seq_state_t st_q, st_d;
  logic [2:0] oc_cnt_q, oc_cnt_d;
  logic oc_flag_q, oc_flag_d;
  logic oc_seen_q, oc_seen_d;
  logic oc_block_q, oc_block_d;
  logic [2:0] hic_q, hic_d;
  logic [CNT_W-1:0] ss_tmr_q, ss_tmr_d;
  logic ev_oc, ev_uv, ev_th, ev_rs;
  logic enable_ok;

  assign enable_ok = ~shdn & rail_ok;

  always_comb begin
    st_d = st_q;
    oc_cnt_d = oc_cnt_q;
    oc_flag_d = oc_flag_q;
    oc_seen_d = oc_seen_q | oc_ev;
    oc_block_d = oc_block_q | oc_ev;
    hic_d = hic_q;
    ss_tmr_d = ss_tmr_q;
    ev_oc = 1'b0;
    ev_uv = 1'b0;
    ev_th = 1'b0;
    ev_rs = 1'b0;
    // count a period once, at its first detection, so the flag rises at once
    if (oc_ev && !oc_seen_q && oc_cnt_q != OC_SHUTDOWN_COUNT) begin
      oc_cnt_d = (oc_cnt_q == '0) ? OC_FIRST_COUNT : oc_cnt_q + 1'b1;
      oc_flag_d = 1'b1;
    end
    if (cycle_start) begin
      oc_block_d = 1'b0;
      oc_seen_d = 1'b0;
      if (!oc_seen_q && !oc_ev) begin
        oc_cnt_d = '0;
        if (oc_cnt_q < OC_FLAG_LIMIT) begin
          oc_flag_d = 1'b0;
        end
      end
    end
    case (st_q)
      ST_OFF: begin
        if (enable_ok && !t_hot) begin
          st_d = ST_SOFTSTART;
        end
      end
      ST_SOFTSTART, ST_RUN: begin
        if (st_q == ST_SOFTSTART && ss_done) begin
          st_d = ST_RUN;
        end
        if (oc_cnt_q == OC_SHUTDOWN_COUNT) begin
          st_d = ST_HICCUP;
          ev_oc = 1'b1;
        end else if (fb_uv && (!oc_flag_q || oc_cnt_q < OC_FLAG_LIMIT)) begin
          st_d = ST_HICCUP;
          ev_uv = 1'b1;
        end
        if (ev_oc || ev_uv) begin
          hic_d = '0;
          ss_tmr_d = '0;
        end
      end
      ST_HICCUP: begin
        ss_tmr_d = inc(ss_tmr_q);
        if (ss_tmr_q == CNT_W'(SS_CYCLES - 1)) begin
          ss_tmr_d = '0;
          hic_d = hic_q + 1'b1;
          if (hic_q == HICCUP_PERIODS - 1'b1) begin
            st_d = ST_SOFTSTART;
            oc_cnt_d = '0;
            oc_flag_d = 1'b0;
            ev_rs = 1'b1;
          end
        end
      end
      ST_THERMAL: begin
        if (t_cool) begin
          st_d = ST_OFF;
        end
      end
      default: st_d = ST_OFF;
    endcase
    if (t_hot && st_q != ST_THERMAL) begin
      st_d = ST_THERMAL;
      ev_th = 1'b1;
    end else if (!enable_ok && st_q != ST_THERMAL) begin
      st_d = ST_OFF;
    end
    if (st_d == ST_OFF || st_d == ST_THERMAL) begin
      oc_cnt_d = '0;
      oc_flag_d = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= ST_OFF;
      oc_cnt_q <= '0;
      oc_flag_q <= 1'b0;
      oc_seen_q <= 1'b0;
      oc_block_q <= 1'b0;
      hic_q <= '0;
      ss_tmr_q <= '0;
    end else if (clk_en) begin
      st_q <= st_d;
      oc_cnt_q <= oc_cnt_d;
      oc_flag_q <= oc_flag_d;
      oc_seen_q <= oc_seen_d;
      oc_block_q <= oc_block_d;
      hic_q <= hic_d;
      ss_tmr_q <= ss_tmr_d;
    end
  end

  logic switching;
  assign switching = (st_q == ST_SOFTSTART || st_q == ST_RUN) && enable_ok;
  // combinational off path so an overcurrent cuts the switch in its own cycle
  assign upper_switch_on = switching && !ramp_reset && !oc_block_q && !oc_ev;
  // soft-start capacitor held discharged unless switching in soft-start or run, so each enable restarts it
  assign ss_discharge = !switching;

  // power-good window filter
  logic pg_raw, pg_out_q, pg_out_d;
  logic [TIMER_W-1:0] pg_tmr_q, pg_tmr_d;
  logic ev_pg;
  assign pg_raw = fb_hi | fb_lo;

  always_comb begin
    pg_out_d = pg_out_q;
    pg_tmr_d = '0;
    ev_pg = 1'b0;
    if (pg_raw != pg_out_q) begin
      pg_tmr_d = pg_tmr_q + 1'b1;
      if (pg_tmr_q == TIMER_W'(PG_FILTER_CYCLES - 1)) begin
        pg_out_d = pg_raw;
        pg_tmr_d = '0;
        ev_pg = pg_raw;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pg_out_q <= 1'b0;
      pg_tmr_q <= '0;
    end else if (clk_en) begin
      pg_out_q <= pg_out_d;
      pg_tmr_q <= pg_tmr_d;
    end
  end

  assign output_in_window_o = 1'b0;
  assign output_in_window_oe = pg_out_q;

  // registers and interrupt
  logic [IRQ_W-1:0] irq_st_q, irq_st_d, irq_mask_q, irq_mask_d, ev_vec;
  logic [7:0] rdata_q, rdata_d;
  assign ev_vec = {ev_rs, ev_pg, ev_th, ev_uv, ev_oc};

  always_comb begin
    irq_st_d = irq_st_q;
    irq_mask_d = irq_mask_q;
    rdata_d = '0;
    if (reg_req.wr && reg_req.addr == REG_IRQ_STATUS) begin
      irq_st_d = irq_st_q & ~reg_req.wdata[IRQ_W-1:0];
    end
    if (reg_req.wr && reg_req.addr == REG_IRQ_MASK) begin
      irq_mask_d = reg_req.wdata[IRQ_W-1:0];
    end
    // set wins over a clear in the same cycle
    irq_st_d = irq_st_d | ev_vec;
    if (reg_req.rd) begin
      case (reg_req.addr)
        REG_STATUS: rdata_d = {pg_out_q, oc_flag_q, shdn, t_hot, 1'b0, st_q};
        REG_IRQ_STATUS: rdata_d = {3'h0, irq_st_q};
        REG_IRQ_MASK: rdata_d = {3'h0, irq_mask_q};
        REG_OC_COUNT: rdata_d = {5'h00, oc_cnt_q};
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_st_q <= '0;
      irq_mask_q <= IRQ_MASK_RESET[IRQ_W-1:0];
      rdata_q <= '0;
    end else if (clk_en) begin
      irq_st_q <= irq_st_d;
      irq_mask_q <= irq_mask_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign irq = |(irq_st_q & irq_mask_q);

  // checks
  a_switch_off_shdn: assert property (@(posedge sys_clk)
    disable iff (!rst_b) shdn |-> !upper_switch_on)
    else $error("switch on during shutdown");
  a_oc_cuts_switch: assert property (@(posedge sys_clk)
    disable iff (!rst_b) oc_ev |-> !upper_switch_on)
    else $error("switch on during overcurrent");
  a_off_time_held: assert property (@(posedge sys_clk)
    disable iff (!rst_b) ramp_reset |-> !upper_switch_on)
    else $error("switch on in off interval");
  a_oc_first_load: assert property (@(posedge sys_clk)
    disable iff (!rst_b || !clk_en)
    oc_ev && !oc_seen_q && oc_cnt_q == 3'h0 && st_d != ST_OFF && st_d != ST_THERMAL
    && st_q != ST_HICCUP |=> oc_cnt_q == 3'h1 && oc_flag_q) else $error("first oc");
  a_oc_clear_cycle: assert property (@(posedge sys_clk)
    disable iff (!rst_b || !clk_en) cycle_start && !oc_seen_q && !oc_ev |=> oc_cnt_q == 3'h0)
    else $error("oc count kept");
  a_oc_flag_drop: assert property (@(posedge sys_clk)
    disable iff (!rst_b || !clk_en)
    cycle_start && !oc_seen_q && !oc_ev && oc_cnt_q < 3'h4 |=> !oc_flag_q)
    else $error("oc flag kept");
  a_oc_seven_fault: assert property (@(posedge sys_clk)
    disable iff (!rst_b || !clk_en)
    st_q == ST_RUN && oc_cnt_q == 3'h7 && !t_hot && enable_ok |=> st_q == ST_HICCUP)
    else $error("no oc fault");
  a_uv_shutdown: assert property (@(posedge sys_clk)
    disable iff (!rst_b || !clk_en)
    st_q == ST_RUN && fb_uv && !oc_flag_q && !t_hot && enable_ok |=> st_q == ST_HICCUP)
    else $error("no uv fault");
  a_sync_ends_ramp: assert property (@(posedge sys_clk)
    disable iff (!rst_b || !clk_en) sync_rise && off_q == '0 |=> ramp_reset)
    else $error("sync edge kept ramp");
  a_thermal_enter: assert property (@(posedge sys_clk)
    disable iff (!rst_b || !clk_en) t_hot |=> st_q == ST_THERMAL)
    else $error("no thermal stop");
  a_hiccup_hold: assert property (@(posedge sys_clk)
    disable iff (!rst_b) st_q == ST_HICCUP |-> !upper_switch_on)
    else $error("switching in hiccup");
  a_pg_filter: assert property (@(posedge sys_clk)
    disable iff (!rst_b || !clk_en) $rose(pg_out_q) |-> $past(pg_raw))
    else $error("pg changed unfiltered");
  c_oc_fault: cover property (@(posedge sys_clk) st_q == ST_RUN ##1 st_q == ST_HICCUP);
  c_hiccup: cover property (@(posedge sys_clk) st_q == ST_HICCUP ##1 st_q == ST_SOFTSTART);
  c_run: cover property (@(posedge sys_clk) st_q == ST_SOFTSTART ##1 st_q == ST_RUN);
  c_thermal: cover property (@(posedge sys_clk) st_q == ST_THERMAL ##1 st_q == ST_OFF);
  c_sync: cover property (@(posedge sys_clk) sync_rise && off_q == '0);
endmodule
`default_nettype wire

// *** hdl/buck_seq_pkg.sv ***
package buck_seq_pkg;
  localparam int unsigned SYS_CLK_HZ = 40000000;
  localparam int unsigned CLK_PERIOD_NS = 25;
  // fixed off interval of each period, least value below 200 ns
  localparam int unsigned OFF_TIME_NS = 150;
  localparam int unsigned OFF_CYCLES = (OFF_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // power-good window filter
  localparam int unsigned PG_FILTER_NS = 3000;
  localparam int unsigned PG_FILTER_CYCLES = PG_FILTER_NS / CLK_PERIOD_NS;
  // free-running period when sync is idle, 2 us (500 kHz)
  localparam int unsigned OSC_PERIOD_NS = 2000;
  localparam int unsigned OSC_PERIOD_CYCLES = OSC_PERIOD_NS / CLK_PERIOD_NS;
  // soft-start period, default 1 ms
  localparam int unsigned SS_PERIOD_US = 1000;
  localparam int unsigned SS_PERIOD_CYCLES = SS_PERIOD_US * 1000 / CLK_PERIOD_NS;
  localparam logic [2:0] OC_SHUTDOWN_COUNT = 3'h7;
  localparam logic [2:0] OC_FLAG_LIMIT = 3'h4;
  localparam logic [2:0] OC_FIRST_COUNT = 3'h1;
  localparam logic [2:0] HICCUP_PERIODS = 3'h4;
  localparam int unsigned CNT_W = 24;
  localparam int unsigned TIMER_W = 8;

  // register map
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_IRQ_STATUS = 4'h1;
  localparam logic [3:0] REG_IRQ_MASK = 4'h2;
  localparam logic [3:0] REG_OC_COUNT = 4'h3;
  localparam logic [7:0] IRQ_MASK_RESET = 8'h00;
  localparam int unsigned IRQ_W = 5;
  localparam int unsigned IRQ_OC_FAULT = 0;
  localparam int unsigned IRQ_UV_FAULT = 1;
  localparam int unsigned IRQ_THERMAL = 2;
  localparam int unsigned IRQ_PG_LOST = 3;
  localparam int unsigned IRQ_RESTART = 4;

  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_SOFTSTART = 3'b001,
    ST_RUN = 3'b011,
    ST_HICCUP = 3'b010,
    ST_THERMAL = 3'b110
  } seq_state_t;

  typedef struct packed {
    logic overcurrent_event;
    logic fb_above_window;
    logic fb_below_window;
    logic fb_undervoltage;
    logic temp_hot;
    logic temp_cool;
    logic input_rail_ok;
    logic ss_done;
  } sense_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
endpackage

// *** hdl/pin_sync3.sv ***
`timescale 1ns/1ps
`default_nettype none
// three-stage synchroniser, a change counts once stages two and three agree
module pin_sync3
  import buck_seq_pkg::*;
#(
  parameter int unsigned W = 1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // pins
  input wire logic [W-1:0] pin_in,
  input wire logic [W-1:0] reset_val,
  output logic [W-1:0] pin_out
);
  logic [W-1:0] s1_q, s2_q, s3_q, out_q;
  logic [W-1:0] out_d;

  always_comb begin
    out_d = out_q;
    for (int i = 0; i < W; i++) begin
      if (s2_q[i] == s3_q[i]) begin
        out_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      out_q <= '0;
    end else if (clk_en) begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      out_q <= out_d;
    end
  end

  assign pin_out = out_q ^ reset_val;
endmodule
`default_nettype wire

// *** test/buck_sense_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module buck_sense_model
  import buck_seq_pkg::*;
#(
  parameter int unsigned SYNC_PERIOD = 60,
  parameter int unsigned SYNC_HIGH = 45,
  parameter int unsigned SS_RAMP = 30
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // scenario control
  input wire logic sync_en,
  input wire sense_t want,
  // power stage
  input wire logic ss_discharge,
  // comparators and sync source
  output var sense_t sense,
  output logic sync_pin
);
  int sync_cnt;
  int ss_cnt;

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_cnt <= 0;
      ss_cnt <= 0;
      sync_pin <= 1'b0;
    end else begin
      sync_cnt <= (sync_cnt + 1 == SYNC_PERIOD) ? 0 : sync_cnt + 1;
      // faster than the 80-cycle free run, and held low when unused
      sync_pin <= sync_en && (sync_cnt < SYNC_HIGH);
      ss_cnt <= ss_discharge ? 0 : ((ss_cnt < SS_RAMP) ? ss_cnt + 1 : ss_cnt);
    end
  end

  always_comb begin
    sense = want;
    // the soft-start node needs time to climb once discharge is released
    sense.ss_done = !ss_discharge && (ss_cnt == SS_RAMP);
  end
endmodule
`default_nettype wire

// *** test/test_buck_fault_hiccup_sequencer.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_buck_fault_hiccup_sequencer;
  import buck_seq_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic shdn_pin = 1'b1;
  logic shdn_oe = 1'b0;
  logic sync_en = 1'b0;
  sense_t want = '0;
  sense_t sense;
  reg_req_t req = '0;
  logic sync_pin, upper_switch_on, ramp_reset, ss_discharge, pg_o, pg_oe, irq;
  logic [7:0] reg_rdata;
  logic [7:0] rd_v;
  int error_cnt = 0;
  int checked = 0;
  int cycles = 0;
  int n;

  always #12.5 sys_clk = ~sys_clk;

  buck_fault_hiccup_sequencer #(.SS_CYCLES(20)) dut_u (
    .sys_clk(sys_clk), .rst_b(rst_b), .clk_en(1'b1),
    .shutdown_req_pin(shdn_pin), .shutdown_req_pin_oe(shdn_oe), .sync_pin(sync_pin),
    .sense(sense), .upper_switch_on(upper_switch_on), .ramp_reset(ramp_reset),
    .ss_discharge(ss_discharge), .output_in_window_o(pg_o), .output_in_window_oe(pg_oe),
    .reg_req(req), .reg_rdata(reg_rdata), .irq(irq)
  );

  buck_sense_model model_u (
    .sys_clk(sys_clk), .rst_b(rst_b), .sync_en(sync_en), .want(want),
    .ss_discharge(ss_discharge), .sense(sense), .sync_pin(sync_pin)
  );

  task automatic stop_test();
    $display("errors=%0d checks=%0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask

  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge sys_clk);
    req.wr <= 1'b0;
  endtask

  task automatic reg_rd(input logic [3:0] a);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge sys_clk);
    req.rd <= 1'b0;
    #1 rd_v = reg_rdata;
    @(posedge sys_clk);
  endtask

  // polls the state field; n is left holding the number of reads
  task automatic wait_st(input logic [2:0] s, input int lim);
    reg_rd(REG_STATUS);
    n = 1;
    while (rd_v[2:0] !== s && n < lim) begin
      reg_rd(REG_STATUS);
      n++;
    end
    chk({5'h00, rd_v[2:0]}, {5'h00, s});
  endtask

  // leaves the bench aligned just after the off interval of a period
  task automatic ramp_meas();
    @(posedge sync_pin);
    n = 0;
    while (ramp_reset !== 1'b1 && n < 12) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk({7'h00, n >= 2 && n <= 7}, 8'h01);
    n = 0;
    while (ramp_reset === 1'b1 && n < 12) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk(8'(n), 8'(OFF_CYCLES));
    chk({7'h00, upper_switch_on}, 8'h01);
    @(posedge sys_clk);
  endtask

  initial begin
    cyc(3);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    reg_rd(REG_IRQ_MASK);
    chk(rd_v, IRQ_MASK_RESET);
    reg_rd(4'hF);
    chk(rd_v, 8'h00);
    want.input_rail_ok <= 1'b1;
    want.temp_cool <= 1'b1;
    cyc(10);
    reg_rd(REG_STATUS);
    chk(rd_v & 8'h27, 8'h20);
    shdn_oe <= 1'b1;
    shdn_pin <= 1'b0;
    sync_en <= 1'b1;
    wait_st(ST_SOFTSTART, 20);
    wait_st(ST_RUN, 60);
    ramp_meas();
    want.overcurrent_event <= 1'b1;
    cyc(5);
    chk({7'h00, upper_switch_on}, 8'h00);
    reg_rd(REG_STATUS);
    chk(rd_v & 8'h40, 8'h40);
    reg_rd(REG_OC_COUNT);
    chk(rd_v, 8'h01);
    cyc(60);
    reg_rd(REG_OC_COUNT);
    chk(rd_v, 8'h02);
    want.fb_undervoltage <= 1'b1;
    wait_st(ST_HICCUP, 10);
    want.overcurrent_event <= 1'b0;
    want.fb_undervoltage <= 1'b0;
    wait_st(ST_SOFTSTART, 60);
    reg_rd(REG_OC_COUNT);
    chk(rd_v, 8'h00);
    reg_wr(REG_IRQ_STATUS, 8'hFF);
    wait_st(ST_RUN, 60);
    ramp_meas();
    want.overcurrent_event <= 1'b1;
    cyc(70);
    want.overcurrent_event <= 1'b0;
    cyc(130);
    reg_rd(REG_STATUS);
    chk(rd_v & 8'h40, 8'h00);
    reg_rd(REG_OC_COUNT);
    chk(rd_v, 8'h00);
    want.overcurrent_event <= 1'b1;
    wait_st(ST_HICCUP, 300);
    chk({7'h00, n > 150}, 8'h01);
    want.overcurrent_event <= 1'b0;
    reg_rd(REG_IRQ_STATUS);
    chk(rd_v & 8'h01, 8'h01);
    chk({7'h00, irq}, 8'h00);
    reg_wr(REG_IRQ_MASK, 8'h01);
    cyc(2);
    chk({7'h00, irq}, 8'h01);
    wait_st(ST_SOFTSTART, 60);
    chk({7'h00, n >= 34 && n <= 44}, 8'h01);
    reg_rd(REG_IRQ_STATUS);
    chk(rd_v & 8'h10, 8'h10);
    reg_wr(REG_IRQ_STATUS, 8'h01);
    cyc(2);
    chk({7'h00, irq}, 8'h00);
    wait_st(ST_RUN, 60);
    want.fb_undervoltage <= 1'b1;
    wait_st(ST_HICCUP, 10);
    want.fb_undervoltage <= 1'b0;
    reg_rd(REG_IRQ_STATUS);
    chk(rd_v & 8'h02, 8'h02);
    wait_st(ST_RUN, 100);
    for (int i = 0; i < 2; i++) begin
      want.fb_above_window <= (i == 0);
      want.fb_below_window <= (i == 1);
      cyc(60);
      chk({7'h00, pg_oe}, 8'h00);
      cyc(100);
      chk({7'h00, pg_oe}, 8'h01);
      reg_rd(REG_IRQ_STATUS);
      chk(rd_v & 8'h08, 8'h08);
      reg_wr(REG_IRQ_STATUS, 8'h08);
      want.fb_above_window <= 1'b0;
      want.fb_below_window <= 1'b0;
      cyc(140);
      chk({7'h00, pg_oe}, 8'h00);
    end
    want.temp_hot <= 1'b1;
    want.temp_cool <= 1'b0;
    wait_st(ST_THERMAL, 10);
    want.temp_hot <= 1'b0;
    cyc(20);
    reg_rd(REG_STATUS);
    chk({5'h00, rd_v[2:0]}, {5'h00, ST_THERMAL});
    want.temp_cool <= 1'b1;
    cyc(10);
    reg_rd(REG_STATUS);
    chk({7'h00, rd_v[2:0] !== ST_THERMAL}, 8'h01);
    wait_st(ST_RUN, 60);
    shdn_pin <= 1'b1;
    wait_st(ST_OFF, 10);
    chk({6'h00, upper_switch_on, ss_discharge}, 8'h01);
    shdn_pin <= 1'b0;
    wait_st(ST_SOFTSTART, 10);
    stop_test();
  end
endmodule
`default_nettype wire
